// file: hdl/bpra_ctrl.sv
`timescale 1ns/10ps
`include "bpra_defs.svh"

// Behaviour
// - Send ack with prefix at ack gap
// - Ack sends no arbitration sequence
// - Power-up loads register defaults
// - Power-up returns state machines to idle
// - Power-up alone drives no bus reset
// - Control request drives bus reset
// - Own bus reset detected like others
// - Detected bus reset reported to link
// - Own detected reset clears initiate bits
// - Live insertion causes no bus reset
// - Arbitrate only on link request
module bpra_ctrl #(
	parameter int BRST_CYC = `BPRA_BRST_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ctl_wr,
	input wire logic [`BPRA_CTL_W-1:0] ctl_wdata,
	input wire logic ack_req,
	input wire logic arb_req,
	input wire logic ack_gap_pin,
	input wire logic sub_gap_pin,
	input wire logic bus_reset_pin,
	output logic [`BPRA_CTL_W-1:0] ctl_rdata,
	output bpra_pkg::bpra_tx_t tx,
	output logic bus_reset_status,
	output logic busy
);
	import bpra_pkg::*;

	// ****************************************
	// Parameter checks
	// ****************************************
	if (BRST_CYC < 1) begin : g_brst_short
		$error("BRST_CYC must be at least one");
	end
	if (BRST_CYC >= (1 << `BPRA_CNT_W)) begin : g_brst_long
		$error("BRST_CYC exceeds counter width");
	end

	logic ack_gap;
	logic sub_gap;
	logic brst_seen;
	logic brst_seen_d_ff;
	logic brst_edge;
	logic [`BPRA_CTL_W-1:0] ctl_ff;
	logic own_ff;
	logic ack_pend_ff;
	logic arb_pend_ff;
	logic status_ff;
	logic [`BPRA_CNT_W-1:0] cnt_ff;
	bpra_state_t state_ff;
	bpra_state_t nxt_state;
	bpra_tx_t tx_ff;
	bpra_tx_t nxt_tx;
	logic init_req;

	// ****************************************
	// Pin inputs
	// ****************************************
	bpra_sync3 u_sync_ack (
		.mclk(mclk),
		.rst(rst),
		.din(ack_gap_pin),
		.dout(ack_gap)
	);
	bpra_sync3 u_sync_sub (
		.mclk(mclk),
		.rst(rst),
		.din(sub_gap_pin),
		.dout(sub_gap)
	);
	bpra_sync3 u_sync_brst (
		.mclk(mclk),
		.rst(rst),
		.din(bus_reset_pin),
		.dout(brst_seen)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			brst_seen_d_ff <= 1'b0;
		end else begin
			brst_seen_d_ff <= brst_seen;
		end
	end

	// Bus reset from any node, own included
	assign brst_edge = brst_seen & ~brst_seen_d_ff;

	// ****************************************
	// Control register
	// ****************************************
	assign init_req = ctl_ff[`BPRA_CTL_INIT_BIT] |
		ctl_ff[`BPRA_CTL_INIT_RED_BIT];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctl_ff <= `BPRA_CTL_RST;
		end else if (ctl_wr) begin
			ctl_ff <= ctl_wdata;
		end else if (brst_edge && own_ff) begin
			ctl_ff <= `BPRA_CTL_RST;
		end
	end

	// Marks a reset this node itself drove
	// Detection wins, else a cut long reset leaves it stuck
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			own_ff <= 1'b0;
		end else if (brst_edge) begin
			own_ff <= 1'b0;
		end else if (state_ff == BPRA_BRST_SEND) begin
			own_ff <= 1'b1;
		end
	end

	// ****************************************
	// Pending link requests
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_pend_ff <= 1'b0;
			arb_pend_ff <= 1'b0;
		end else if (brst_edge) begin
			ack_pend_ff <= 1'b0;
			arb_pend_ff <= 1'b0;
		end else begin
			ack_pend_ff <= ack_req | (ack_pend_ff & state_ff != BPRA_ACK_SEND);
			arb_pend_ff <= arb_req | (arb_pend_ff & state_ff != BPRA_ARB_SEND);
		end
	end

	// ****************************************
	// Access state machine
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_tx = '0;
		unique case (state_ff)
			BPRA_IDLE: begin
				// No reset from power-up or insertion alone
				if (init_req && !own_ff) begin
					nxt_state = BPRA_BRST_SEND;
				end else if (ack_pend_ff) begin
					nxt_state = BPRA_ACK_WAIT;
				end else if (arb_pend_ff) begin
					nxt_state = BPRA_ARB_WAIT;
				end
			end
			BPRA_ACK_WAIT: begin
				if (ack_gap) begin
					nxt_state = BPRA_ACK_SEND;
				end
			end
			BPRA_ACK_SEND: begin
				nxt_tx.tx_prefix = 1'b1;
				nxt_state = BPRA_IDLE;
			end
			BPRA_ARB_WAIT: begin
				if (sub_gap) begin
					nxt_state = BPRA_ARB_SEND;
				end
			end
			BPRA_ARB_SEND: begin
				nxt_tx.tx_arb_seq = 1'b1;
				nxt_state = BPRA_IDLE;
			end
			BPRA_BRST_SEND: begin
				nxt_tx.tx_bus_reset = 1'b1;
				if (cnt_ff == `BPRA_CNT_W'(BRST_CYC - 1)) begin
					nxt_state = BPRA_IDLE;
				end
			end
		endcase
		if (brst_edge) begin
			nxt_state = BPRA_IDLE;
			nxt_tx = '0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= BPRA_IDLE;
			tx_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			tx_ff <= nxt_tx;
		end
	end

	// ****************************************
	// Bus reset length
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
		end else if (state_ff == BPRA_BRST_SEND) begin
			cnt_ff <= cnt_ff + 1'b1;
		end else begin
			cnt_ff <= '0;
		end
	end

	// ****************************************
	// Status to link
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status_ff <= 1'b0;
		end else begin
			status_ff <= brst_edge;
		end
	end

	assign ctl_rdata = ctl_ff;
	assign tx = tx_ff;
	assign bus_reset_status = status_ff;
	assign busy = state_ff != BPRA_IDLE;
endmodule : bpra_ctrl

// file: hdl/bpra_defs.svh
`ifndef BPRA_DEFS_SVH
`define BPRA_DEFS_SVH

// Control register bit positions
`define BPRA_CTL_INIT_BIT 0
`define BPRA_CTL_INIT_RED_BIT 1
`define BPRA_CTL_W 2
`define BPRA_CTL_RST 2'h0

// Bus reset signalling length in ns and derived cycles
`define BPRA_CLK_NS 10
`define BPRA_BRST_NS 1000
`define BPRA_BRST_CYC ((`BPRA_BRST_NS + `BPRA_CLK_NS - 1) / `BPRA_CLK_NS)
`define BPRA_CNT_W 16

`endif

// file: hdl/bpra_pkg.sv
package bpra_pkg;
	typedef enum logic [2:0] {
		BPRA_IDLE,
		BPRA_ACK_WAIT,
		BPRA_ACK_SEND,
		BPRA_ARB_WAIT,
		BPRA_ARB_SEND,
		BPRA_BRST_SEND
	} bpra_state_t;

	typedef struct packed {
		logic ack_req;
		logic arb_req;
		logic brst_req;
		logic reduced;
	} bpra_req_t;

	typedef struct packed {
		logic tx_prefix;
		logic tx_arb_seq;
		logic tx_bus_reset;
	} bpra_tx_t;
endpackage : bpra_pkg

// file: hdl/bpra_sync3.sv
`timescale 1ns/10ps
module bpra_sync3 (
	input wire logic mclk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic dout_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Change accepted once stages two and three agree
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dout_ff <= 1'b0;
		end else if (s2_ff == s3_ff) begin
			dout_ff <= s3_ff;
		end
	end

	assign dout = dout_ff;
endmodule : bpra_sync3

// file: tb/bpra_bus_model.sv
`timescale 1ns/10ps
module bpra_bus_model (
	input wire logic mclk,
	input wire bpra_pkg::bpra_tx_t tx,
	input wire logic ext,
	output logic bus_reset_pin
);
	import bpra_pkg::*;
	// Own reset seen on the bus like a peer's
	always_ff @(posedge mclk) begin
		bus_reset_pin <= tx.tx_bus_reset | ext;
	end
endmodule : bpra_bus_model

// file: tb/bpra_ctrl_properties.sv
`timescale 1ns/10ps
`include "bpra_defs.svh"
module bpra_ctrl_properties #(
	parameter int BRST_CYC = `BPRA_BRST_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ctl_wr,
	input wire logic [`BPRA_CTL_W-1:0] ctl_wdata,
	input wire logic [`BPRA_CTL_W-1:0] ctl_rdata,
	input wire bpra_pkg::bpra_tx_t tx,
	input wire logic bus_reset_pin,
	input wire logic bus_reset_status,
	input wire logic busy
);
	import bpra_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	ack_no_arb_a: assert property (tx.tx_prefix |->
		!tx.tx_arb_seq && !$past(tx.tx_arb_seq)) else $error("arb with ack");
	ctl_write_a: assert property (ctl_wr |=> ctl_rdata == $past(ctl_wdata))
		else $error("write lost");
	brst_start_a: assert property (ctl_wr && ctl_wdata != 0 &&
		ctl_rdata == 0 && !busy |-> ##3 tx.tx_bus_reset) else $error("no reset");
	brst_end_a: assert property ($rose(tx.tx_bus_reset) |->
		##[1:BRST_CYC] !tx.tx_bus_reset) else $error("reset too long");
	brst_cause_a: assert property ($rose(tx.tx_bus_reset) |->
		$past(ctl_rdata) != 0) else $error("reset uncaused");
	status_pulse_a: assert property (bus_reset_status |=> !bus_reset_status)
		else $error("status long");
	status_det_a: assert property ($rose(bus_reset_pin) |->
		##[2:10] bus_reset_status) else $error("no status");
	own_clear_a: assert property ($rose(tx.tx_bus_reset) |->
		##[2:20] ctl_rdata == 0) else $error("bits kept");
	cover property (tx.tx_prefix);
	cover property (tx.tx_arb_seq);
	cover property (bus_reset_status);
	cover property ($rose(tx.tx_bus_reset));
endmodule : bpra_ctrl_properties
bind bpra_ctrl bpra_ctrl_properties #(
	.BRST_CYC(BRST_CYC)
) chk (
	.mclk(mclk),
	.rst(rst),
	.ctl_wr(ctl_wr),
	.ctl_wdata(ctl_wdata),
	.ctl_rdata(ctl_rdata),
	.tx(tx),
	.bus_reset_pin(bus_reset_pin),
	.bus_reset_status(bus_reset_status),
	.busy(busy)
);

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
	import bpra_pkg::*;
	logic mclk = 1'h0, rst = 1'h1, ctl_wr = 1'h0, ack_req = 1'h0;
	logic arb_req = 1'h0, ext = 1'h0;
	logic ack_gap_pin = 1'h0, sub_gap_pin = 1'h0, bus_reset_pin;
	logic bus_reset_status, busy;
	logic [1:0] ctl_wdata = 2'h0, ctl_rdata;
	bpra_tx_t tx;
	int miscompares = 0, num_checks = 0, np, na, nb, ns, m_reg;
	always #5 mclk = ~mclk;
	localparam int BRST_LEN = 4;
	bpra_ctrl #(
		.BRST_CYC(BRST_LEN)
	) uut (
		.mclk(mclk),
		.rst(rst),
		.ctl_wr(ctl_wr),
		.ctl_wdata(ctl_wdata),
		.ack_req(ack_req),
		.arb_req(arb_req),
		.ack_gap_pin(ack_gap_pin),
		.sub_gap_pin(sub_gap_pin),
		.bus_reset_pin(bus_reset_pin),
		.ctl_rdata(ctl_rdata),
		.tx(tx),
		.bus_reset_status(bus_reset_status),
		.busy(busy)
	);
	bpra_bus_model bus (.mclk(mclk), .tx(tx), .ext(ext),
		.bus_reset_pin(bus_reset_pin));
	always @(posedge mclk) begin
		np += tx.tx_prefix;
		na += tx.tx_arb_seq;
		nb += tx.tx_bus_reset;
		ns += bus_reset_status;
	end
	task chk(string n, logic [7:0] s, logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %0d seen %0d", n, e, s);
		end
	endtask : chk
	task cyc(int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task clr;
		np = 0; na = 0; nb = 0; ns = 0;
	endtask : clr
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	initial begin
		#20000;
		miscompares++;
		summarize;
	end
	initial begin
		void'($urandom(41039));
		cyc(12);
		rst <= 1'h0;
		clr;
		cyc(20);
		chk("rdata", 8'(ctl_rdata), 8'h00);
		chk("brst", nb[7:0], 8'h00);
		chk("busy", 8'(busy), 8'h00);
		$display("test power_up done");
		for (int v = 1; v < 3; v++) begin
			clr;
			m_reg = v;
			ctl_wr <= 1'h1;
			ctl_wdata <= v[1:0];
			cyc(2);
			ctl_wr <= 1'h0;
			#1 chk("wr", 8'(ctl_rdata), m_reg[7:0]);
			cyc(40);
			m_reg = 0;
			chk("brst", nb[7:0], 8'(BRST_LEN));
			chk("sts", ns[7:0], 8'h01);
			chk("clr", 8'(ctl_rdata), m_reg[7:0]);
			$display("test own_reset %0d done", v);
		end
		clr;
		ext <= 1'h1;
		cyc(5 + $urandom % 4);
		ext <= 1'h0;
		cyc(20);
		chk("sts", ns[7:0], 8'h01);
		chk("brst", nb[7:0], 8'h00);
		$display("test peer_reset done");
		clr;
		ack_req <= 1'h1;
		cyc(1);
		ack_req <= 1'h0;
		ack_gap_pin <= 1'h1;
		cyc(12);
		ack_gap_pin <= 1'h0;
		chk("ack", np[7:0], 8'h01);
		chk("arb", na[7:0], 8'h00);
		sub_gap_pin <= 1'h1;
		cyc(12);
		chk("arb", na[7:0], 8'h00);
		sub_gap_pin <= 1'h0;
		arb_req <= 1'h1;
		cyc(1);
		arb_req <= 1'h0;
		sub_gap_pin <= 1'h1;
		cyc(12);
		sub_gap_pin <= 1'h0;
		chk("arb", na[7:0], 8'h01);
		$display("test access done");
		summarize;
	end
endmodule : tb
